// ==== rtl/mfscr_defs.vh ====
// Constants for the flow, speed and max-frame configuration register bank
`ifndef MFSCR_DEFS_VH
`define MFSCR_DEFS_VH
// ====================================================================
// Register byte addresses
`define MFSCR_ADDR_FLOW      12'h040c
`define MFSCR_ADDR_SPEED     12'h0410
`define MFSCR_ADDR_RXMAX     12'h0414
`define MFSCR_ADDR_TXMAX     12'h0418
`define MFSCR_ADDR_REV       12'h04f8
`define MFSCR_ADDR_CAP       12'h04fc
`define MFSCR_ADDR_OVS       12'h0420
// ====================================================================
// Field positions
`define MFSCR_FLOW_TX_BIT    30
`define MFSCR_FLOW_RX_BIT    29
`define MFSCR_SPEED_HI       31
`define MFSCR_SPEED_LO       30
`define MFSCR_MAX_EN_BIT     16
`define MFSCR_MAX_LEN_HI     14
`define MFSCR_OVS_RX_BIT     0
`define MFSCR_OVS_TX_BIT     1
`define MFSCR_TAG_RX_BIT     2
`define MFSCR_TAG_TX_BIT     3
// ====================================================================
// Reset values and codes
`define MFSCR_FLOW_RST       1'b1
`define MFSCR_SPEED_10M      2'b00
`define MFSCR_SPEED_100M     2'b01
`define MFSCR_SPEED_1G       2'b10
`define MFSCR_MAX_LEN_RST    15'h05ee
`define MFSCR_STD_LEN        15'h05ee
`define MFSCR_TAG_LEN        15'h05f2
`define MFSCR_JUMBO_LEN      15'h7fff
`endif

// ==== rtl/mfscr_limit.v ====
// Frame length limit selection for one direction
module mfscr_limit (
   input  wire        oversize_en_in,
   input  wire        max_en_in,
   input  wire        tag_en_in,
   input  wire [14:0] max_len_in,
   output reg  [14:0] limit_out
);
`include "mfscr_defs.vh"
   always @* begin
      if (oversize_en_in) begin
         limit_out = `MFSCR_JUMBO_LEN; // RULE_08
      end else if (max_en_in) begin
         limit_out = max_len_in; // RULE_06
      end else if (tag_en_in) begin
         limit_out = `MFSCR_TAG_LEN; // RULE_07
      end else begin
         limit_out = `MFSCR_STD_LEN;
      end
   end
endmodule // mfscr_limit

// ==== rtl/mfscr_regs.v ====
// Flow control, speed and max-frame configuration register bank
// Overview of operation
// (RULE_01) Tx flow enable gates pause requests
// (RULE_02) Rx flow enable lets pause inhibit transmitter
// (RULE_03) Speed field codes; gigabit-only build fixed 10
// (RULE_04) Low-speed build accepts only codes 00, 01
// (RULE_05) Speed setting survives reset
// (RULE_06) Rx limit: standard/tagged or programmed length
// (RULE_07) Tx limit: standard/tagged or programmed length
// (RULE_08) Oversize enable overrides max-frame settings
// (RULE_09) Revision register: major, minor, patch fields
// (RULE_10) Capability bits 2..0 report supported speeds
// (RULE_11) Capability bits 10..8 report build options
// (RULE_12) Rx oversize enable accepts frames above maximum
// (RULE_13) Reserved bits read zero, writes ignored
module mfscr_regs #(
   parameter       CAP_1G     = 1,
   parameter       CAP_100M   = 1,
   parameter       CAP_10M    = 1,
   parameter       CAP_FILT   = 1,
   parameter       CAP_HALF   = 1,
   parameter       CAP_STATS  = 1,
   parameter [7:0] REV_MAJOR  = 8'h01, // Arbitrary value
   parameter [7:0] REV_MINOR  = 8'h00, // Arbitrary value
   parameter [7:0] REV_PATCH  = 8'h00  // Arbitrary value
) (
   input  wire        clk_sys_in,
   input  wire        rst_in,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        pause_req_in,
   input  wire        rx_pause_frame_in,
   output reg         tx_pause_send_out,
   output reg         tx_inhibit_out,
   output reg         rx_pause_to_client_out,
   output reg  [1:0]  line_speed_out,
   output reg  [14:0] rx_frame_limit_out,
   output reg  [14:0] tx_frame_limit_out,
   output reg         rx_oversize_accept_out
);
`include "mfscr_defs.vh"
   // =================================================================
   // Register state
   reg         flow_tx_q;
   reg         flow_rx_q;
   reg  [1:0]  speed_q;
   reg         rx_max_en_q;
   reg  [14:0] rx_max_len_q;
   reg         tx_max_en_q;
   reg  [14:0] tx_max_len_q;
   reg         ovs_rx_q;
   reg         ovs_tx_q;
   reg         tag_rx_q;
   reg         tag_tx_q;
   reg         aw_got_q;
   reg  [11:0] aw_addr_q;
   reg         w_got_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   wire [14:0] rx_limit;
   wire [14:0] tx_limit;
   wire        only_1g;
   wire        only_low;
   wire        do_write;
   wire [31:0] rx_len_mrg;
   wire [31:0] tx_len_mrg;

   assign only_1g  = (CAP_1G != 0) && (CAP_100M == 0) && (CAP_10M == 0);
   assign only_low = (CAP_1G == 0);
   assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
   assign rx_len_mrg = merge({17'h0_0000, rx_max_len_q}, w_data_q, w_strb_q);
   assign tx_len_mrg = merge({17'h0_0000, tx_max_len_q}, w_data_q, w_strb_q);

   // Byte-lane merge of write data
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer i;
      begin
         merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // Known register address
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `MFSCR_ADDR_FLOW) || (a == `MFSCR_ADDR_SPEED) ||
                  (a == `MFSCR_ADDR_RXMAX) || (a == `MFSCR_ADDR_TXMAX) ||
                  (a == `MFSCR_ADDR_REV) || (a == `MFSCR_ADDR_CAP) ||
                  (a == `MFSCR_ADDR_OVS);
      end
   endfunction

   // Current register image with reserved bits zero
   function [31:0] image;
      input [11:0] a;
      begin
         image = 32'h0000_0000; // RULE_13
         if (a == `MFSCR_ADDR_FLOW) begin
            image[`MFSCR_FLOW_TX_BIT] = flow_tx_q;
            image[`MFSCR_FLOW_RX_BIT] = flow_rx_q;
         end else if (a == `MFSCR_ADDR_SPEED) begin
            image[`MFSCR_SPEED_HI:`MFSCR_SPEED_LO] = speed_q;
         end else if (a == `MFSCR_ADDR_RXMAX) begin
            image[`MFSCR_MAX_EN_BIT] = rx_max_en_q;
            image[`MFSCR_MAX_LEN_HI:0] = rx_max_len_q;
         end else if (a == `MFSCR_ADDR_TXMAX) begin
            image[`MFSCR_MAX_EN_BIT] = tx_max_en_q;
            image[`MFSCR_MAX_LEN_HI:0] = tx_max_len_q;
         end else if (a == `MFSCR_ADDR_REV) begin
            image = {REV_MAJOR, REV_MINOR, 8'h00, REV_PATCH}; // RULE_09
         end else if (a == `MFSCR_ADDR_CAP) begin
            image[10] = (CAP_FILT != 0);  // RULE_11
            image[9]  = (CAP_HALF != 0);  // RULE_11
            image[8]  = (CAP_STATS != 0); // RULE_11
            image[2]  = (CAP_1G != 0);    // RULE_10
            image[1]  = (CAP_100M != 0);  // RULE_10
            image[0]  = (CAP_10M != 0);   // RULE_10
         end else if (a == `MFSCR_ADDR_OVS) begin
            image[`MFSCR_OVS_RX_BIT] = ovs_rx_q;
            image[`MFSCR_OVS_TX_BIT] = ovs_tx_q;
            image[`MFSCR_TAG_RX_BIT] = tag_rx_q;
            image[`MFSCR_TAG_TX_BIT] = tag_tx_q;
         end
      end
   endfunction

   // =================================================================
   // Write channels
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= 12'h000;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end else begin
         s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q      <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q      <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_q) ? 2'b00 : 2'b10;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
         end
      end
   end

   // =================================================================
   // Configuration registers
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         flow_tx_q    <= `MFSCR_FLOW_RST;
         flow_rx_q    <= `MFSCR_FLOW_RST;
         rx_max_en_q  <= 1'b0;
         rx_max_len_q <= `MFSCR_MAX_LEN_RST;
         tx_max_en_q  <= 1'b0;
         tx_max_len_q <= `MFSCR_MAX_LEN_RST;
         ovs_rx_q     <= 1'b0;
         ovs_tx_q     <= 1'b0;
         tag_rx_q     <= 1'b0;
         tag_tx_q     <= 1'b0;
      end else if (do_write) begin
         if (aw_addr_q == `MFSCR_ADDR_FLOW) begin
            if (w_strb_q[3]) begin
               flow_tx_q <= w_data_q[`MFSCR_FLOW_TX_BIT];
               flow_rx_q <= w_data_q[`MFSCR_FLOW_RX_BIT];
            end
         end else if (aw_addr_q == `MFSCR_ADDR_RXMAX) begin
            if (w_strb_q[2]) begin
               rx_max_en_q <= w_data_q[`MFSCR_MAX_EN_BIT];
            end
            rx_max_len_q <= rx_len_mrg[`MFSCR_MAX_LEN_HI:0];
         end else if (aw_addr_q == `MFSCR_ADDR_TXMAX) begin
            if (w_strb_q[2]) begin
               tx_max_en_q <= w_data_q[`MFSCR_MAX_EN_BIT];
            end
            tx_max_len_q <= tx_len_mrg[`MFSCR_MAX_LEN_HI:0];
         end else if (aw_addr_q == `MFSCR_ADDR_OVS) begin
            if (w_strb_q[0]) begin
               ovs_rx_q <= w_data_q[`MFSCR_OVS_RX_BIT];
               ovs_tx_q <= w_data_q[`MFSCR_OVS_TX_BIT];
               tag_rx_q <= w_data_q[`MFSCR_TAG_RX_BIT];
               tag_tx_q <= w_data_q[`MFSCR_TAG_TX_BIT];
            end
         end
      end
   end

   // =================================================================
   // Speed register, untouched by reset
   initial speed_q = `MFSCR_SPEED_1G;
   always @(posedge clk_sys_in) begin // RULE_05
      if (only_1g) begin
         speed_q <= `MFSCR_SPEED_1G; // RULE_03
      end else if (!rst_in && do_write && w_strb_q[3] &&
                   aw_addr_q == `MFSCR_ADDR_SPEED) begin
         if (only_low) begin
            if (!w_data_q[`MFSCR_SPEED_HI]) begin
               speed_q <= w_data_q[`MFSCR_SPEED_HI:`MFSCR_SPEED_LO]; // RULE_04
            end
         end else if (w_data_q[`MFSCR_SPEED_HI:`MFSCR_SPEED_LO] != 2'b11) begin
            speed_q <= w_data_q[`MFSCR_SPEED_HI:`MFSCR_SPEED_LO]; // RULE_03
         end
      end
   end

   // =================================================================
   // Read channel
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= image(s_axi_araddr);
            s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =================================================================
   // Frame limits
   mfscr_limit u_rx_limit (
      .oversize_en_in (ovs_rx_q),
      .max_en_in      (rx_max_en_q),
      .tag_en_in      (tag_rx_q),
      .max_len_in     (rx_max_len_q),
      .limit_out      (rx_limit)
   );

   mfscr_limit u_tx_limit (
      .oversize_en_in (ovs_tx_q),
      .max_en_in      (tx_max_en_q),
      .tag_en_in      (tag_tx_q),
      .max_len_in     (tx_max_len_q),
      .limit_out      (tx_limit)
   );

   // =================================================================
   // Outputs to the transmitter and receiver
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         tx_pause_send_out      <= 1'b0;
         tx_inhibit_out         <= 1'b0;
         rx_pause_to_client_out <= 1'b0;
         line_speed_out         <= `MFSCR_SPEED_1G;
         rx_frame_limit_out     <= `MFSCR_STD_LEN;
         tx_frame_limit_out     <= `MFSCR_STD_LEN;
         rx_oversize_accept_out <= 1'b0;
      end else begin
         tx_pause_send_out      <= pause_req_in && flow_tx_q; // RULE_01
         tx_inhibit_out         <= rx_pause_frame_in && flow_rx_q; // RULE_02
         rx_pause_to_client_out <= rx_pause_frame_in && !flow_rx_q; // RULE_02
         line_speed_out         <= speed_q;
         rx_frame_limit_out     <= rx_limit; // RULE_06
         tx_frame_limit_out     <= tx_limit; // RULE_07
         rx_oversize_accept_out <= ovs_rx_q; // RULE_12
      end
   end
endmodule // mfscr_regs

// ==== verif/mfscr_regs_chk.sv ====
// Assertion checker for the configuration register bank
`include "mfscr_defs.vh"
module mfscr_regs_chk (
   input wire        clk_sys_in,
   input wire        rst_in,
   input wire [11:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        pause_req_in,
   input wire        rx_pause_frame_in,
   input wire        tx_pause_send_out,
   input wire        tx_inhibit_out,
   input wire        rx_pause_to_client_out,
   input wire [1:0]  line_speed_out,
   input wire [14:0] rx_frame_limit_out,
   input wire        rx_oversize_accept_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // ================================================================
   // Address of the read in flight
   reg [11:0] ar_q;
   always @(posedge clk_sys_in) begin
      if (s_axi_arvalid && s_axi_arready)
         ar_q <= s_axi_araddr;
   end
   // ================================================================
   // Properties
   pause_src_a: assert property (
      tx_pause_send_out |-> $past(pause_req_in))
      else $error("pause sent without request");
   inhibit_src_a: assert property (
      tx_inhibit_out |-> $past(rx_pause_frame_in))
      else $error("inhibit without received pause");
   forward_src_a: assert property (
      rx_pause_to_client_out |-> $past(rx_pause_frame_in))
      else $error("forward without received pause");
   flow_excl_a: assert property (
      !(tx_inhibit_out && rx_pause_to_client_out))
      else $error("pause both inhibits and forwards");
   speed_code_a: assert property (
      line_speed_out != 2'b11)
      else $error("illegal speed code");
   rx_ovs_a: assert property (
      rx_oversize_accept_out |-> rx_frame_limit_out == 15'h7fff)
      else $error("oversize limit wrong");
   rst_state_a: assert property (disable iff (1'b0)
      rst_in |=> rx_frame_limit_out == 15'h05ee && !s_axi_rvalid)
      else $error("state after reset wrong");
   flow_resv_a: assert property (
      s_axi_rvalid && ar_q == `MFSCR_ADDR_FLOW |->
      !s_axi_rdata[31] && s_axi_rdata[28:0] == 29'h0)
      else $error("flow reserved bits set");
   id_resv_a: assert property (
      s_axi_rvalid && ar_q == `MFSCR_ADDR_REV |-> s_axi_rdata[15:8] == 8'h00)
      else $error("revision reserved bits set");
   cap_resv_a: assert property (
      s_axi_rvalid && ar_q == `MFSCR_ADDR_CAP |->
      s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[7:3] == 5'h00)
      else $error("capability reserved bits set");
   pause_c: cover property (tx_pause_send_out);
   fwd_c: cover property (rx_pause_to_client_out);
   ovs_c: cover property (rx_oversize_accept_out);
endmodule // mfscr_regs_chk
bind mfscr_regs mfscr_regs_chk mfscr_regs_chk_inst (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .pause_req_in(pause_req_in), .rx_pause_frame_in(rx_pause_frame_in),
   .tx_pause_send_out(tx_pause_send_out), .tx_inhibit_out(tx_inhibit_out),
   .rx_pause_to_client_out(rx_pause_to_client_out),
   .line_speed_out(line_speed_out),
   .rx_frame_limit_out(rx_frame_limit_out),
   .rx_oversize_accept_out(rx_oversize_accept_out));

// ==== verif/mfscr_regs_tb.sv ====
// Self-checking testbench for the configuration register bank
`include "mfscr_defs.vh"
module mfscr_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys_in, rst_in, pause_req_in, rx_pause_frame_in;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic        tx_pause_send_out, tx_inhibit_out, rx_pause_to_client_out;
   logic        rx_oversize_accept_out;
   logic [1:0]  s_axi_bresp, s_axi_rresp, line_speed_out;
   logic [1:0]  line_speed_gig, line_speed_low;
   logic [3:0]  s_axi_wstrb;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [14:0] rx_frame_limit_out, tx_frame_limit_out;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   int          n_fail, n_compared, cyc;
   mfscr_regs mfscr_regs_inst (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .pause_req_in(pause_req_in),
      .rx_pause_frame_in(rx_pause_frame_in),
      .tx_pause_send_out(tx_pause_send_out),
      .tx_inhibit_out(tx_inhibit_out),
      .rx_pause_to_client_out(rx_pause_to_client_out),
      .line_speed_out(line_speed_out),
      .rx_frame_limit_out(rx_frame_limit_out),
      .tx_frame_limit_out(tx_frame_limit_out),
      .rx_oversize_accept_out(rx_oversize_accept_out));
   // Gigabit-only build
   mfscr_regs #(.CAP_100M(0), .CAP_10M(0)) mfscr_regs_gig_inst (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(),
      .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
      .pause_req_in(pause_req_in), .rx_pause_frame_in(rx_pause_frame_in),
      .tx_pause_send_out(), .tx_inhibit_out(), .rx_pause_to_client_out(),
      .line_speed_out(line_speed_gig), .rx_frame_limit_out(),
      .tx_frame_limit_out(), .rx_oversize_accept_out());
   // Build limited to 10 and 100 Mb/s
   mfscr_regs #(.CAP_1G(0)) mfscr_regs_low_inst (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(),
      .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
      .pause_req_in(pause_req_in), .rx_pause_frame_in(rx_pause_frame_in),
      .tx_pause_send_out(), .tx_inhibit_out(), .rx_pause_to_client_out(),
      .line_speed_out(line_speed_low), .rx_frame_limit_out(),
      .tx_frame_limit_out(), .rx_oversize_accept_out());
   // ================================================================
   // Common tasks
   task results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bit b;
      b = 0;
      @(posedge clk_sys_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!b) begin
         @(posedge clk_sys_in);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 0;
         if (s_axi_bvalid) begin
            b = 1;
            s_axi_bready <= 0;
            chk(s_axi_bresp, (a == 12'h04f0) ? 2'b10 : 2'b00);
         end
      end
      repeat (2) @(posedge clk_sys_in);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      bit r;
      r = 0;
      @(posedge clk_sys_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!r) begin
         @(posedge clk_sys_in);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 0;
         if (s_axi_rvalid) begin
            r = 1;
            s_axi_rready <= 0;
            chk(s_axi_rdata, ed);
            chk(s_axi_rresp, er);
         end
      end
   endtask
   // ================================================================
   // Scenarios
   task t_reset;
      rd(`MFSCR_ADDR_FLOW, 32'h6000_0000, 2'b00);
      rd(`MFSCR_ADDR_SPEED, 32'h8000_0000, 2'b00);
      rd(`MFSCR_ADDR_RXMAX, 32'h0000_05ee, 2'b00);
      rd(`MFSCR_ADDR_TXMAX, 32'h0000_05ee, 2'b00);
      rd(`MFSCR_ADDR_REV, 32'h0100_0000, 2'b00);
      rd(`MFSCR_ADDR_CAP, 32'h0000_0707, 2'b00);
      chk(tx_frame_limit_out, 32'h0000_05ee);
   endtask
   task t_flow;
      pause_req_in <= 1;
      rx_pause_frame_in <= 1;
      repeat (2) @(posedge clk_sys_in);
      chk({tx_pause_send_out, tx_inhibit_out, rx_pause_to_client_out},
          32'h0000_0006);
      wr(`MFSCR_ADDR_FLOW, 32'h4000_0000);
      chk({tx_pause_send_out, tx_inhibit_out, rx_pause_to_client_out},
          32'h0000_0005);
      wr(`MFSCR_ADDR_FLOW, 32'h0000_0000);
      chk({tx_pause_send_out, tx_inhibit_out, rx_pause_to_client_out},
          32'h0000_0001);
      wr(`MFSCR_ADDR_FLOW, 32'hffff_ffff);
      rd(`MFSCR_ADDR_FLOW, 32'h6000_0000, 2'b00);
      pause_req_in <= 0;
      rx_pause_frame_in <= 0;
   endtask
   task t_speed;
      for (int i = 0; i < 4; i++) begin
         wr(`MFSCR_ADDR_SPEED, {i[1:0], 30'h3fff_ffff});
         rd(`MFSCR_ADDR_SPEED, (i == 3) ? 32'h8000_0000 : i << 30, 2'b00);
         chk(line_speed_out, (i == 3) ? 2'b10 : i);
         chk(line_speed_gig, 2'b10);
         chk(line_speed_low, (i == 0) ? 2'b00 : 2'b01);
      end
      wr(`MFSCR_ADDR_SPEED, 32'h4000_0000);
      rst_in <= 1;
      repeat (4) @(posedge clk_sys_in);
      rst_in <= 0;
      rd(`MFSCR_ADDR_SPEED, 32'h4000_0000, 2'b00);
      chk(line_speed_out, 2'b01);
      chk(line_speed_low, 2'b01);
      chk(line_speed_gig, 2'b10);
   endtask
   task t_frame;
      wr(`MFSCR_ADDR_RXMAX, 32'h0001_0100);
      chk(rx_frame_limit_out, 32'h0000_0100);
      wr(`MFSCR_ADDR_OVS, 32'h0000_0004);
      chk(rx_frame_limit_out, 32'h0000_0100);
      wr(`MFSCR_ADDR_RXMAX, 32'h0000_0100);
      chk(rx_frame_limit_out, 32'h0000_05f2);
      wr(`MFSCR_ADDR_OVS, 32'h0000_0001);
      chk({rx_oversize_accept_out, rx_frame_limit_out}, 32'h0000_ffff);
      wr(`MFSCR_ADDR_TXMAX, 32'hffff_0200);
      rd(`MFSCR_ADDR_TXMAX, 32'h0001_0200, 2'b00);
      wr(`MFSCR_ADDR_OVS, 32'h0000_0008);
      chk(tx_frame_limit_out, 32'h0000_0200);
      wr(`MFSCR_ADDR_OVS, 32'h0000_0002);
      chk(tx_frame_limit_out, 32'h0000_7fff);
      wr(`MFSCR_ADDR_OVS, 32'h0000_0008);
      wr(`MFSCR_ADDR_TXMAX, 32'h0000_0200);
      chk(tx_frame_limit_out, 32'h0000_05f2);
      wr(`MFSCR_ADDR_OVS, 32'h0000_0000);
      chk(tx_frame_limit_out, 32'h0000_05ee);
      rd(12'h04f0, 32'h0000_0000, 2'b10);
      wr(12'h04f0, 32'hffff_ffff);
   endtask
   // ================================================================
   // Clock, timeout and main sequence
   initial begin
      clk_sys_in = 0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      {rst_in, s_axi_wstrb} = 5'h1f;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, pause_req_in, rx_pause_frame_in} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 0;
      t_reset();
      t_flow();
      t_speed();
      t_frame();
      results();
   end
endmodule // mfscr_regs_tb
